/* hdl/gcmd_pkg.sv */
// constants shared by the general bus command handler and its setting registers
// assumes bus commands arrive already decoded, one strobe per command
package gcmd_pkg;

	// ----------------------------------------------------------------
	// bus address
	// ----------------------------------------------------------------
	localparam int ADDR_W = 5;
	localparam logic [4:0] ADDR_RST = 5'h12; // decimal 18

	// ----------------------------------------------------------------
	// setting fields: widths, selectors and power-up values
	// ----------------------------------------------------------------
	localparam int SET_W = 16;
	localparam int SEL_W = 4;
	localparam int STEP_W = 7;
	localparam int SRC_W = 3;
	localparam int FMT_W = 2;
	localparam int EOI_W = 2;
	localparam int MASK_W = 8;
	localparam int DOUT_W = 4;
	localparam int SETTLE_W = 16;
	localparam int TERM_W = 3;
	localparam int ROWS_W = 8;
	localparam int SPOLL_W = 8;

	localparam logic [3:0] SEL_RELAY_STEP = 4'h0;
	localparam logic [3:0] SEL_MEM_STEP = 4'h1;
	localparam logic [3:0] SEL_EXT_EDGE = 4'h2;
	localparam logic [3:0] SEL_READY_SENSE = 4'h3;
	localparam logic [3:0] SEL_EDIT_PTR = 4'h4;
	localparam logic [3:0] SEL_TRIG_EN = 4'h5;
	localparam logic [3:0] SEL_DATA_FMT = 4'h6;
	localparam logic [3:0] SEL_EOI = 4'h7;
	localparam logic [3:0] SEL_SRQ_MASK = 4'h8;
	localparam logic [3:0] SEL_DIG_OUT = 4'h9;
	localparam logic [3:0] SEL_SETTLE = 4'ha;
	localparam logic [3:0] SEL_TRIG_SRC = 4'hb;
	localparam logic [3:0] SEL_TERM = 4'hc;
	localparam logic [3:0] SEL_MB_ROWS = 4'hd;
	localparam logic [3:0] SEL_BM_ROWS = 4'he;

	localparam logic [6:0] RELAY_STEP_RST = 7'h00;
	localparam logic [6:0] MEM_STEP_RST = 7'h01;
	localparam logic [6:0] EDIT_PTR_RST = 7'h00;
	localparam logic [2:0] TRIG_SRC_RST = 3'h7; // external trigger
	localparam logic [2:0] TRIG_SRC_GET = 3'h5; // bus group trigger source
	localparam logic [0:0] BIT_RST = 1'h0;
	localparam logic [1:0] FMT_RST = 2'h0;
	localparam logic [1:0] EOI_RST = 2'h0;
	localparam logic [7:0] MASK_RST = 8'h00;
	localparam logic [3:0] DOUT_RST = 4'h0;
	localparam logic [15:0] SETTLE_RST = 16'h0000;
	localparam logic [2:0] TERM_RST = 3'h0; // cr lf
	localparam logic [7:0] ROWS_RST = 8'h00;

endpackage : gcmd_pkg

/* hdl/gcmd_field.sv */
// one setting register: power-up value, cleared to it, loaded by a select match
// assumes clear and load strobes are synchronous to core_clk
`timescale 1ns/100ps
`default_nettype none

module gcmd_field
#(
	parameter int W = 1,
	parameter logic [W-1:0] RST = '0
)
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic clr,
	input wire logic wr,
	input wire logic [W-1:0] wr_val,
	output logic [W-1:0] q
);

	logic [W-1:0] d;

	// clear beats a write in the same cycle so a device clear always lands
	always_comb
	begin
		d = q;
		if (clr)
			d = RST;
		else if (wr)
			d = wr_val;
	end

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			q <= RST;
		else
			q <= d;
	end

endmodule // gcmd_field

`default_nettype wire

/* hdl/gcmd_handler.sv */
// general bus command handler: remote/local, lockout, talker/listener, clears,
// group trigger and serial poll for the instrument
// assumes decoded command strobes, one cycle each, synchronous to core_clk
`timescale 1ns/100ps
`default_nettype none

// Behaviour
// (R1) enter remote only when addressed to listen while remote enable is true
// (R2) controller asserts remote enable, then addresses listen before programming data
// (R3) interface clear forces local, talker idle and listener idle
// (R4) interface clear switches off talk and listen indicators
// (R5) in remote only local key and power pass; local key restores panel
// (R6) talker addressing works in local and in remote alike
// (R7) lockout blocks every panel key including local; only power passes
// (R8) go-to-local leaves remote; keys stay blocked while lockout holds
// (R9) lockout clears only when remote enable goes false
// (R10) universal device clear restores power-up defaults without addressing
// (R11) device clear leaves the bus primary address unchanged
// (R12) selective clear acts only while addressed to listen
// (R13) group trigger starts setup change only with bus trigger source selected
// (R14) serial poll returns status byte whenever polled, service request or not
// (R15) primary address defaults to 18; power-up and clear keep programmed address; here rst reloads 18
// (R16) clear opens relays, relay step 000, memory step 001, keeps setups and rows
// (R17) clear sets full output, triggers and srq off, external source, zeros
// (R18) factory restore keeps the bus primary address
// (R19) power up stand-alone; slave only when master initialises loop at power-up
// (R20) clear keeps master/slave role; a master also clears its slaves
// (R21) remote indicator follows remote state, not the remote enable level
// (R22) talk lit when talker active, listen when listener active; each idles other
// (R23) reset gives local, no lockout, talker and listener idle
// (R24) remote, lockout, talker and listener states are status outputs
module gcmd_handler
	import gcmd_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic ren,
	input wire logic ifc,
	input wire logic mla,
	input wire logic mta,
	input wire logic ota,
	input wire logic unl,
	input wire logic unt,
	input wire logic llo_cmd,
	input wire logic gtl_cmd,
	input wire logic dcl_cmd,
	input wire logic sdc_cmd,
	input wire logic get_cmd,
	input wire logic spe_cmd,
	input wire logic spd_cmd,
	input wire logic [7:0] spoll_status,
	input wire logic key_strobe,
	input wire logic key_is_local,
	input wire logic key_is_power,
	input wire logic factory_restore_command,
	input wire logic set_wr,
	input wire logic [3:0] set_sel,
	input wire logic [15:0] set_val,
	input wire logic addr_wr,
	input wire logic [4:0] addr_val,
	input wire logic is_master,
	input wire logic ms_loop_init,
	input wire logic ms_init_done,
	output logic remote_q,
	output logic lockout_q,
	output logic talk_q,
	output logic listen_q,
	output logic key_pass_q,
	output logic clear_q,
	output logic relays_open_q,
	output logic setups_clear_q,
	output logic clear_slaves_q,
	output logic trig_start_q,
	output logic spoll_q,
	output logic [7:0] spoll_out_q,
	output logic [4:0] addr_q,
	output logic slave_q,
	output logic [6:0] relay_step_q,
	output logic [6:0] mem_step_q,
	output logic [6:0] edit_ptr_q,
	output logic ext_edge_q,
	output logic ready_sense_q,
	output logic trig_en_q,
	output logic [1:0] data_fmt_q,
	output logic [1:0] eoi_q,
	output logic [7:0] srq_mask_q,
	output logic [3:0] dig_out_q,
	output logic [15:0] settle_q,
	output logic [2:0] trig_src_q,
	output logic [2:0] term_q,
	output logic [7:0] mb_rows_q,
	output logic [7:0] bm_rows_q
);

	// ----------------------------------------------------------------
	// interface state
	// ----------------------------------------------------------------
	logic remote_d, lockout_d, talk_d, listen_d, key_pass_d, spoll_d;
	logic [7:0] spoll_out_d;
	logic key_local_ok;

	// local key is honoured only outside lockout
	assign key_local_ok = key_strobe && key_is_local && !lockout_q;

	// addressing, remote and lockout; ifc is checked last so it wins
	always_comb
	begin
		remote_d = remote_q;
		lockout_d = lockout_q;
		talk_d = talk_q;
		listen_d = listen_q;
		if (mla)
		begin
			listen_d = 1'b1;
			talk_d = 1'b0; // see (R22)
			if (ren)
				remote_d = 1'b1; // see (R1)
		end
		else if (mta)
		begin
			talk_d = 1'b1; // see (R6)
			listen_d = 1'b0; // see (R22)
		end
		if (unl)
			listen_d = 1'b0;
		if (unt || ota)
			talk_d = 1'b0;
		if (gtl_cmd && listen_q && !mla)
			remote_d = 1'b0; // see (R8)
		if (key_local_ok && !mla)
			remote_d = 1'b0; // see (R5)
		if (llo_cmd && ren)
			lockout_d = 1'b1; // see (R7)
		if (!ren)
		begin
			lockout_d = 1'b0; // see (R9)
			remote_d = 1'b0;
		end
		if (ifc)
		begin
			remote_d = 1'b0; // see (R3)
			talk_d = 1'b0; // see (R4)
			listen_d = 1'b0; // see (R4)
		end
	end

	// panel key gate: power always, local outside lockout, rest only in local outside lockout
	always_comb
	begin
		key_pass_d = 1'b0;
		if (key_strobe)
		begin
			if (key_is_power)
				key_pass_d = 1'b1;
			else if (key_is_local)
				key_pass_d = !lockout_q; // see (R7)
			else
				key_pass_d = !remote_q && !lockout_q; // see (R5)
		end
	end

	// serial poll mode; the byte is offered whenever polled as talker
	always_comb
	begin
		spoll_d = spoll_q;
		spoll_out_d = spoll_out_q;
		if (spe_cmd)
			spoll_d = 1'b1;
		if (spd_cmd || ifc)
			spoll_d = 1'b0;
		if (spoll_q && talk_q)
			spoll_out_d = spoll_status; // see (R14)
	end

	// remote_q drives the remote indicator directly, never the ren level
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			remote_q <= 1'b0; // see (R23)
			lockout_q <= 1'b0;
			talk_q <= 1'b0;
			listen_q <= 1'b0;
			key_pass_q <= 1'b0;
			spoll_q <= 1'b0;
			spoll_out_q <= 8'h00;
		end
		else
		begin
			remote_q <= remote_d; // see (R21)
			lockout_q <= lockout_d; // see (R24)
			talk_q <= talk_d;
			listen_q <= listen_d;
			key_pass_q <= key_pass_d;
			spoll_q <= spoll_d;
			spoll_out_q <= spoll_out_d;
		end
	end

	// ----------------------------------------------------------------
	// clears, trigger, address and master/slave role
	// ----------------------------------------------------------------
	logic clear_d, setups_clear_d, clear_slaves_d, trig_start_d, slave_d, init_win_q, init_win_d;
	logic [4:0] addr_d;
	logic dev_clear, fld_clr;

	// sdc only counts while addressed to listen; dcl needs no addressing
	assign dev_clear = dcl_cmd || (sdc_cmd && listen_q); // see (R10) (R12)

	always_comb
	begin
		clear_d = dev_clear;
		setups_clear_d = factory_restore_command;
		clear_slaves_d = dev_clear && is_master; // see (R20)
		trig_start_d = get_cmd && listen_q && (trig_src_q == TRIG_SRC_GET); // see (R13)
		addr_d = addr_wr ? addr_val : addr_q; // see (R11) (R15) (R18)
		init_win_d = init_win_q && !ms_init_done;
		slave_d = slave_q;
		if (ms_loop_init && init_win_q && !is_master)
			slave_d = 1'b1; // see (R19)
	end

	// the address is only ever reset by power-on, to its factory value;
	// a real part would keep it in non-volatile storage outside this block
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			clear_q <= 1'b0;
			setups_clear_q <= 1'b0;
			clear_slaves_q <= 1'b0;
			trig_start_q <= 1'b0;
			addr_q <= ADDR_RST; // see (R15)
			slave_q <= 1'b0; // see (R19)
			init_win_q <= 1'b1;
		end
		else
		begin
			clear_q <= clear_d;
			setups_clear_q <= setups_clear_d;
			clear_slaves_q <= clear_slaves_d;
			trig_start_q <= trig_start_d;
			addr_q <= addr_d;
			slave_q <= slave_d; // see (R20)
			init_win_q <= init_win_d;
		end
	end

	// relays open with clear_q, one cycle before the reloaded defaults appear
	assign relays_open_q = clear_q; // see (R16)

	// ----------------------------------------------------------------
	// setting registers
	// ----------------------------------------------------------------
	// defaults land one cycle after the clear strobe; factory restore does it too
	assign fld_clr = clear_q || setups_clear_q;

	gcmd_field #(.W(STEP_W), .RST(RELAY_STEP_RST)) u_relay_step (.core_clk(core_clk),
		.rst(rst), .clr(fld_clr), .wr(set_wr && set_sel == SEL_RELAY_STEP),
		.wr_val(set_val[STEP_W-1:0]), .q(relay_step_q)); // see (R16)
	gcmd_field #(.W(STEP_W), .RST(MEM_STEP_RST)) u_mem_step (.core_clk(core_clk),
		.rst(rst), .clr(fld_clr), .wr(set_wr && set_sel == SEL_MEM_STEP),
		.wr_val(set_val[STEP_W-1:0]), .q(mem_step_q)); // see (R16)
	gcmd_field #(.W(STEP_W), .RST(EDIT_PTR_RST)) u_edit_ptr (.core_clk(core_clk),
		.rst(rst), .clr(fld_clr), .wr(set_wr && set_sel == SEL_EDIT_PTR),
		.wr_val(set_val[STEP_W-1:0]), .q(edit_ptr_q));
	gcmd_field #(.W(1), .RST(BIT_RST)) u_ext_edge (.core_clk(core_clk),
		.rst(rst), .clr(fld_clr), .wr(set_wr && set_sel == SEL_EXT_EDGE),
		.wr_val(set_val[0]), .q(ext_edge_q));
	gcmd_field #(.W(1), .RST(BIT_RST)) u_ready_sense (.core_clk(core_clk),
		.rst(rst), .clr(fld_clr), .wr(set_wr && set_sel == SEL_READY_SENSE),
		.wr_val(set_val[0]), .q(ready_sense_q));
	gcmd_field #(.W(1), .RST(BIT_RST)) u_trig_en (.core_clk(core_clk),
		.rst(rst), .clr(fld_clr), .wr(set_wr && set_sel == SEL_TRIG_EN),
		.wr_val(set_val[0]), .q(trig_en_q)); // see (R17)
	gcmd_field #(.W(FMT_W), .RST(FMT_RST)) u_data_fmt (.core_clk(core_clk),
		.rst(rst), .clr(fld_clr), .wr(set_wr && set_sel == SEL_DATA_FMT),
		.wr_val(set_val[FMT_W-1:0]), .q(data_fmt_q)); // see (R17)
	gcmd_field #(.W(EOI_W), .RST(EOI_RST)) u_eoi (.core_clk(core_clk),
		.rst(rst), .clr(fld_clr), .wr(set_wr && set_sel == SEL_EOI),
		.wr_val(set_val[EOI_W-1:0]), .q(eoi_q));
	gcmd_field #(.W(MASK_W), .RST(MASK_RST)) u_srq_mask (.core_clk(core_clk),
		.rst(rst), .clr(fld_clr), .wr(set_wr && set_sel == SEL_SRQ_MASK),
		.wr_val(set_val[MASK_W-1:0]), .q(srq_mask_q)); // see (R17)
	gcmd_field #(.W(DOUT_W), .RST(DOUT_RST)) u_dig_out (.core_clk(core_clk),
		.rst(rst), .clr(fld_clr), .wr(set_wr && set_sel == SEL_DIG_OUT),
		.wr_val(set_val[DOUT_W-1:0]), .q(dig_out_q)); // see (R17)
	gcmd_field #(.W(SETTLE_W), .RST(SETTLE_RST)) u_settle (.core_clk(core_clk),
		.rst(rst), .clr(fld_clr), .wr(set_wr && set_sel == SEL_SETTLE),
		.wr_val(set_val[SETTLE_W-1:0]), .q(settle_q)); // see (R17)
	gcmd_field #(.W(SRC_W), .RST(TRIG_SRC_RST)) u_trig_src (.core_clk(core_clk),
		.rst(rst), .clr(fld_clr), .wr(set_wr && set_sel == SEL_TRIG_SRC),
		.wr_val(set_val[SRC_W-1:0]), .q(trig_src_q)); // see (R17)
	gcmd_field #(.W(TERM_W), .RST(TERM_RST)) u_term (.core_clk(core_clk),
		.rst(rst), .clr(fld_clr), .wr(set_wr && set_sel == SEL_TERM),
		.wr_val(set_val[TERM_W-1:0]), .q(term_q)); // see (R17)
	// row selections survive device clear; only factory restore resets them
	gcmd_field #(.W(ROWS_W), .RST(ROWS_RST)) u_mb_rows (.core_clk(core_clk),
		.rst(rst), .clr(setups_clear_q), .wr(set_wr && set_sel == SEL_MB_ROWS),
		.wr_val(set_val[ROWS_W-1:0]), .q(mb_rows_q)); // see (R16)
	gcmd_field #(.W(ROWS_W), .RST(ROWS_RST)) u_bm_rows (.core_clk(core_clk),
		.rst(rst), .clr(setups_clear_q), .wr(set_wr && set_sel == SEL_BM_ROWS),
		.wr_val(set_val[ROWS_W-1:0]), .q(bm_rows_q)); // see (R16)

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	AST_REMOTE_NEEDS_LISTEN: assert property ($rose(remote_q) |-> $past(mla && ren)) // see (R1)
		else $error("remote entered without listen address and ren");
	AST_IFC_IDLE: assert property (ifc |=> !remote_q && !talk_q && !listen_q) // see (R3)
		else $error("ifc did not idle the interface");
	AST_REMOTE_KEYS: assert property (key_strobe && remote_q && !key_is_local
		&& !key_is_power |=> !key_pass_q) // see (R5)
		else $error("panel key passed in remote");
	AST_LOCKOUT_KEYS: assert property (key_strobe && lockout_q && !key_is_power
		|=> !key_pass_q) // see (R7)
		else $error("panel key passed under lockout");
	AST_LOCKOUT_HOLD: assert property (lockout_q && ren |=> lockout_q) // see (R9)
		else $error("lockout released while ren true");
	AST_GTL_LOCAL: assert property (gtl_cmd && listen_q && !mla |=> !remote_q) // see (R8)
		else $error("gtl left device in remote");
	AST_DCL_CLEAR: assert property (dcl_cmd |=> clear_q ##1 (trig_src_q == TRIG_SRC_RST
		&& settle_q == SETTLE_RST && !trig_en_q && mem_step_q == MEM_STEP_RST)) // see (R10)
		else $error("dcl did not restore defaults");
	AST_SDC_ADDRESSED: assert property (sdc_cmd && !listen_q && !dcl_cmd |=> !clear_q) // see (R12)
		else $error("sdc acted while not listening");
	AST_ADDR_KEPT: assert property (!$past(addr_wr) |-> $stable(addr_q)) // see (R11)
		else $error("bus address changed without a write");
	AST_GET_SOURCE: assert property (get_cmd && listen_q
		|=> trig_start_q == ($past(trig_src_q) == TRIG_SRC_GET)) // see (R13)
		else $error("group trigger mishandled");
	AST_SPOLL_BYTE: assert property (spoll_q && talk_q |=> spoll_out_q == $past(spoll_status)) // see (R14)
		else $error("serial poll byte not returned");
	AST_SLAVE_CLEAR: assert property (clear_q |-> clear_slaves_q == $past(is_master)) // see (R20)
		else $error("slave clear wrong for role");
	AST_TALK_LISTEN: assert property (mla && !ifc |=> listen_q && !talk_q) // see (R22)
		else $error("listen addressing did not idle talker");
	AST_ROWS_KEPT: assert property (clear_q && !setups_clear_q && !set_wr
		|=> $stable(mb_rows_q)) // see (R16)
		else $error("device clear altered row selections");

	COV_REMOTE: cover property (ren && mla ##1 remote_q);
	COV_LOCKOUT_GTL: cover property (lockout_q && gtl_cmd && listen_q);
	COV_GET_TRIG: cover property (trig_start_q);
	COV_SPOLL: cover property (spoll_q && talk_q);

endmodule // gcmd_handler

`default_nettype wire

/* tb/gcmd_ctl_model.sv */
// bus controller model: remote enable level and decoded command strobes
// assumes the handler samples every strobe on the rising edge of core_clk
`timescale 1ns/100ps
`default_nettype none

module gcmd_ctl_model
(
	input wire logic core_clk,
	output logic ren,
	output logic ifc,
	output logic mla,
	output logic mta,
	output logic ota,
	output logic unl,
	output logic unt,
	output logic llo_cmd,
	output logic gtl_cmd,
	output logic dcl_cmd,
	output logic sdc_cmd,
	output logic get_cmd,
	output logic spe_cmd,
	output logic spd_cmd
);
	logic [12:0] strobes;

	// ----------------------------------------------------------------
	// strobe fan-out
	// ----------------------------------------------------------------
	// one bit per command, so a burst of several commands in one cycle is possible too
	assign {spd_cmd, spe_cmd, get_cmd, sdc_cmd, dcl_cmd, gtl_cmd, llo_cmd, unt, unl, ota, mta, mla,
		ifc} = strobes;

	// idle bus: remote enable false and no command in flight
	initial
	begin
		ren = 1'b0;
		strobes = '0;
	end

	// remote enable goes up before any listen addressing, and down to drop lockout
	task automatic set_ren(input logic v);
		@(negedge core_clk);
		ren = v;
	endtask

	// one command for one clock; gap idles afterwards to mimic a slow controller
	task automatic cmd(input logic [12:0] m, input int gap);
		@(negedge core_clk);
		strobes = m;
		@(negedge core_clk);
		strobes = '0;
		repeat (gap) @(negedge core_clk);
	endtask
endmodule // gcmd_ctl_model

`default_nettype wire

/* tb/tb_gcmd_handler.sv */
// testbench for the general bus command handler, directed plus seeded random
// assumes the controller model drives the bus side at falling edges
`timescale 1ns/100ps
`default_nettype none

module tb_gcmd_handler
	import gcmd_pkg::*;
;
	localparam logic [12:0] M_IFC = 13'h0001, M_MLA = 13'h0002, M_MTA = 13'h0004,
		M_OTA = 13'h0008, M_UNL = 13'h0010, M_UNT = 13'h0020, M_LLO = 13'h0040,
		M_GTL = 13'h0080, M_DCL = 13'h0100, M_SDC = 13'h0200, M_GET = 13'h0400,
		M_SPE = 13'h0800, M_SPD = 13'h1000;
	localparam logic [15:0] FMASK [15] = '{16'h007f, 16'h007f, 16'h0001, 16'h0001, 16'h007f,
		16'h0001, 16'h0003, 16'h0003, 16'h00ff, 16'h000f, 16'hffff, 16'h0007, 16'h0007,
		16'h00ff, 16'h00ff};
	localparam logic [15:0] DEF [15] = '{16'(RELAY_STEP_RST), 16'(MEM_STEP_RST), 16'(BIT_RST),
		16'(BIT_RST), 16'(EDIT_PTR_RST), 16'(BIT_RST), 16'(FMT_RST), 16'(EOI_RST), 16'(MASK_RST),
		16'(DOUT_RST), SETTLE_RST, 16'(TRIG_SRC_RST), 16'(TERM_RST), 16'(ROWS_RST), 16'(ROWS_RST)};

	logic core_clk, rst, key_strobe, key_is_local, key_is_power, factory_restore_command;
	logic set_wr, addr_wr, is_master, ms_loop_init, ms_init_done;
	logic [3:0] set_sel;
	logic [15:0] set_val;
	logic [4:0] addr_val, ea;
	logic [7:0] spoll_status;
	logic ren, ifc, mla, mta, ota, unl, unt, llo_cmd, gtl_cmd, dcl_cmd, sdc_cmd, get_cmd;
	logic spe_cmd, spd_cmd, remote_q, lockout_q, talk_q, listen_q, key_pass_q, clear_q;
	logic relays_open_q, setups_clear_q, clear_slaves_q, trig_start_q, spoll_q, slave_q;
	logic ext_edge_q, ready_sense_q, trig_en_q;
	logic [7:0] spoll_out_q, srq_mask_q, mb_rows_q, bm_rows_q;
	logic [4:0] addr_q;
	logic [6:0] relay_step_q, mem_step_q, edit_ptr_q;
	logic [1:0] data_fmt_q, eoi_q;
	logic [3:0] dig_out_q;
	logic [15:0] settle_q;
	logic [2:0] trig_src_q, term_q;
	logic [15:0] wv [15];
	logic [31:0] seed, r;
	int num_errors = 0;
	int cmp_count = 0;

	gcmd_ctl_model ctl (.core_clk, .ren, .ifc, .mla, .mta, .ota, .unl, .unt, .llo_cmd, .gtl_cmd,
		.dcl_cmd, .sdc_cmd, .get_cmd, .spe_cmd, .spd_cmd);

	gcmd_handler dut (.core_clk, .rst, .ren, .ifc, .mla, .mta, .ota, .unl, .unt, .llo_cmd,
		.gtl_cmd, .dcl_cmd, .sdc_cmd, .get_cmd, .spe_cmd, .spd_cmd, .spoll_status, .key_strobe,
		.key_is_local, .key_is_power, .factory_restore_command, .set_wr, .set_sel, .set_val,
		.addr_wr, .addr_val, .is_master, .ms_loop_init, .ms_init_done, .remote_q, .lockout_q,
		.talk_q, .listen_q, .key_pass_q, .clear_q, .relays_open_q, .setups_clear_q,
		.clear_slaves_q, .trig_start_q, .spoll_q, .spoll_out_q, .addr_q, .slave_q, .relay_step_q,
		.mem_step_q, .edit_ptr_q, .ext_edge_q, .ready_sense_q, .trig_en_q, .data_fmt_q, .eoi_q,
		.srq_mask_q, .dig_out_q, .settle_q, .trig_src_q, .term_q, .mb_rows_q, .bm_rows_q);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	// row selections survive a device clear but not a factory restore
	function automatic logic [15:0] exp_after(input int s, input logic keep_rows);
		if (keep_rows && s >= 13)
			return wv[s] & FMASK[s];
		return DEF[s];
	endfunction

	function automatic logic kexp(input logic loc, input logic pwr, input logic rem,
		input logic lck);
		return pwr | (loc & !lck) | (!rem & !lck);
	endfunction

	function automatic logic [15:0] rd(input int s);
		case (s)
			0: return 16'(relay_step_q);
			1: return 16'(mem_step_q);
			2: return 16'(ext_edge_q);
			3: return 16'(ready_sense_q);
			4: return 16'(edit_ptr_q);
			5: return 16'(trig_en_q);
			6: return 16'(data_fmt_q);
			7: return 16'(eoi_q);
			8: return 16'(srq_mask_q);
			9: return 16'(dig_out_q);
			10: return settle_q;
			11: return 16'(trig_src_q);
			12: return 16'(term_q);
			13: return 16'(mb_rows_q);
			default: return 16'(bm_rows_q);
		endcase
	endfunction

	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		cmp_count++;
		if (g !== e)
		begin
			num_errors++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic st(input logic [3:0] e);
		chk("remote_lockout_talk_listen", 16'(e), 16'({remote_q, lockout_q, talk_q, listen_q}));
	endtask

	task automatic strobe(ref logic s);
		@(negedge core_clk);
		s = 1'b1;
		@(negedge core_clk);
		s = 1'b0;
	endtask

	task automatic key(input logic loc, input logic pwr, input logic rem, input logic lck);
		@(negedge core_clk);
		key_strobe = 1'b1;
		key_is_local = loc;
		key_is_power = pwr;
		@(negedge core_clk);
		key_strobe = 1'b0;
		chk("key_pass", 16'(kexp(loc, pwr, rem, lck)), 16'(key_pass_q));
	endtask

	task automatic setf(input int s, input logic [15:0] v);
		@(negedge core_clk);
		set_wr = 1'b1;
		set_sel = 4'(s);
		set_val = v;
		@(negedge core_clk);
		set_wr = 1'b0;
	endtask

	task automatic reset_dut();
		rst = 1'b1;
		repeat (16) @(posedge core_clk);
		@(negedge core_clk);
		rst = 1'b0;
	endtask

	task automatic done(input string t);
		$display("test %s finished", t);
	endtask

	task automatic conclude();
		$display("comparisons %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// 40 MHz core clock
	initial
	begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end

	// the whole run needs well under a thousand cycles
	initial
	begin
		repeat (5000) @(posedge core_clk);
		num_errors++;
		conclude();
	end

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	initial
	begin
		{key_strobe, key_is_local, key_is_power, factory_restore_command, set_wr} = '0;
		{addr_wr, is_master, ms_loop_init, ms_init_done, set_sel, set_val, addr_val} = '0;
		spoll_status = 8'h00;
		seed = 32'h0116;
		reset_dut();
		st(4'b0000);
		chk("addr", 16'(ADDR_RST), 16'(addr_q));
		for (int s = 0; s < 15; s++)
			chk("field", DEF[s], rd(s));
		done("reset");
		ctl.set_ren(1'b1);
		ctl.cmd('0, 2);
		st(4'b0000);
		ctl.cmd(M_MLA, 0);
		st(4'b1001);
		ctl.cmd(M_MTA, 0);
		st(4'b1010);
		ctl.cmd(M_UNT, 0);
		st(4'b1000);
		ctl.cmd(M_MTA, 0);
		ctl.cmd(M_OTA, 0);
		st(4'b1000);
		key(1'b0, 1'b0, 1'b1, 1'b0);
		key(1'b0, 1'b1, 1'b1, 1'b0);
		key(1'b1, 1'b0, 1'b1, 1'b0);
		st(4'b0000);
		ctl.set_ren(1'b0);
		ctl.cmd(M_MTA, 0);
		st(4'b0010);
		ctl.set_ren(1'b1);
		ctl.cmd(M_MLA, 0);
		ctl.cmd(M_MTA, 0);
		st(4'b1010);
		ctl.cmd(M_IFC, 0);
		st(4'b0000);
		done("remote_and_addressing");
		ctl.cmd(M_LLO, 0);
		st(4'b0100);
		key(1'b1, 1'b0, 1'b0, 1'b1);
		key(1'b0, 1'b1, 1'b0, 1'b1);
		ctl.cmd(M_MLA, 0);
		st(4'b1101);
		ctl.cmd(M_GTL, 0);
		st(4'b0101);
		key(1'b0, 1'b0, 1'b0, 1'b1);
		ctl.set_ren(1'b0);
		ctl.cmd('0, 0);
		st(4'b0001);
		ctl.cmd(M_LLO, 0);
		st(4'b0001);
		key(1'b0, 1'b0, 1'b0, 1'b0);
		done("lockout");
		ctl.set_ren(1'b1);
		ctl.cmd(M_UNL, 0);
		setf(11, 16'(TRIG_SRC_GET));
		ctl.cmd(M_GET, 0);
		chk("trig_start", 16'h0000, 16'(trig_start_q));
		ctl.cmd(M_SDC, 0);
		chk("clear", 16'h0000, 16'(clear_q));
		ctl.cmd(M_MLA, 0);
		ctl.cmd(M_GET, 0);
		chk("trig_start", 16'h0001, 16'(trig_start_q));
		setf(11, 16'(TRIG_SRC_RST));
		ctl.cmd(M_GET, 0);
		chk("trig_start", 16'h0000, 16'(trig_start_q));
		ctl.cmd(M_SDC, 0);
		chk("clear", 16'h0001, 16'(clear_q));
		done("trigger_and_selective_clear");
		is_master = 1'b1;
		for (int s = 0; s < 15; s++)
		begin
			r = xs();
			wv[s] = r[15:0];
			setf(s, wv[s]);
			chk("field_write", wv[s] & FMASK[s], rd(s));
		end
		r = xs();
		ea = r[4:0];
		@(negedge core_clk);
		addr_wr = 1'b1;
		addr_val = ea;
		@(negedge core_clk);
		addr_wr = 1'b0;
		ctl.cmd(M_UNL, 0);
		ctl.cmd(M_DCL, 0);
		chk("clear", 16'h0001, 16'(clear_q));
		chk("relays_open", 16'h0001, 16'(relays_open_q));
		chk("clear_slaves", 16'h0001, 16'(clear_slaves_q));
		@(negedge core_clk);
		for (int s = 0; s < 15; s++)
			chk("field_after_clear", exp_after(s, 1'b1), rd(s));
		chk("addr", 16'(ea), 16'(addr_q));
		strobe(factory_restore_command);
		chk("setups_clear", 16'h0001, 16'(setups_clear_q));
		@(negedge core_clk);
		for (int s = 0; s < 15; s++)
			chk("field_after_restore", exp_after(s, 1'b0), rd(s));
		chk("addr", 16'(ea), 16'(addr_q));
		done("clears");
		r = xs();
		spoll_status = r[7:0];
		ctl.cmd(M_SPE, 0);
		chk("spoll", 16'h0001, 16'(spoll_q));
		ctl.cmd(M_MTA, 1);
		chk("spoll_out", 16'(r[7:0]), 16'(spoll_out_q));
		ctl.cmd(M_SPD, 0);
		chk("spoll", 16'h0000, 16'(spoll_q));
		done("serial_poll");
		is_master = 1'b0;
		reset_dut();
		chk("slave", 16'h0000, 16'(slave_q));
		strobe(ms_init_done);
		strobe(ms_loop_init);
		chk("slave_late_init", 16'h0000, 16'(slave_q));
		reset_dut();
		strobe(ms_loop_init);
		ctl.cmd('0, 0);
		chk("slave", 16'h0001, 16'(slave_q));
		ctl.cmd(M_DCL, 0);
		chk("clear_slaves", 16'h0000, 16'(clear_slaves_q));
		@(negedge core_clk);
		chk("slave", 16'h0001, 16'(slave_q));
		strobe(ms_init_done);
		reset_dut();
		chk("slave", 16'h0000, 16'(slave_q));
		done("master_slave");
		conclude();
	end
endmodule // tb_gcmd_handler

`default_nettype wire
